// ===== meter_aux_register_bank.sv
// auxiliary register bank: pin port, operating hours, calendar,
// monitor selector and stream control behind a word register port.
// assumes the serial control link decodes frames into single-cycle
// read and write requests and that INTERVAL_TICK marks interval ends.
`timescale 1ns/1ns
`include "meter_aux_regs.svh"
module meter_aux_register_bank #(
  parameter int STREAM_PERIOD_CYC = `STREAM_PERIOD_CYC,
  parameter int SECOND_CYC = `SECOND_CYC,
  parameter int unsigned HOUR_FRACTION_CYC = `HOUR_FRACTION_CYC
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input meter_aux_pkg::reg_req_t REG_REQ,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [7:0] GENERAL_PINS_IN,
  output logic [7:0] GENERAL_PINS_OUT,
  output logic [7:0] GENERAL_PINS_OE,
  input wire logic INTERVAL_TICK,
  output logic PIN_EDGE_FLAG,
  input wire logic MONITOR_ENABLE,
  input wire logic [1:0] TEST_OUTPUT_SELECT,
  input wire logic MONITOR_SERIAL,
  output logic [31:0] MONITOR_SLOT_ADDR,
  output logic TEST_OUT,
  output logic ENGINE_RD,
  output logic [7:0] ENGINE_ADDR,
  input wire logic [31:0] ENGINE_DATA,
  output logic STREAM_CLOCK,
  output logic STREAM_DATA,
  output logic FRAME_PULSE
);
  meter_aux_pkg::top_t st_r;
  meter_aux_pkg::top_t st_nxt;
  logic [31:0] time_word;
  logic [31:0] date_word;
  logic wr_pins;
  logic wr_time;
  logic wr_date;
  logic hour_tick;
  logic [7:0] edges;
  logic [7:0] new_dir;
  logic ser_busy;

  assign wr_pins = REG_REQ.wr && REG_REQ.addr == `REG_PIN_CTRL;
  assign wr_time = REG_REQ.wr && REG_REQ.addr == `REG_TIME_DAY;
  assign wr_date = REG_REQ.wr && REG_REQ.addr == `REG_DATE;
  assign hour_tick = st_r.hour_pre == 32'(HOUR_FRACTION_CYC - 1);
  assign edges = (GENERAL_PINS_IN ^ st_r.pin_prev) & st_r.pin_mask;
  assign new_dir = REG_REQ.wdata[`PIN_DIR_LSB +: 8];

  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_prev = GENERAL_PINS_IN;
    // pin control: value, direction and edge mask; bits 15-8 dropped
    if (wr_pins) begin
      st_nxt.pin_dir = new_dir;
      st_nxt.pin_mask = REG_REQ.wdata[`PIN_MASK_LSB +: 8];
      st_nxt.pin_out = (st_r.pin_out & ~new_dir) |
                       (REG_REQ.wdata[`PIN_VALUE_LSB +: 8] & new_dir);
    end
    // edges caught now are reported at the next interval boundary;
    // an edge in the boundary cycle itself goes to the next interval
    if (INTERVAL_TICK) begin
      st_nxt.edge_flag = st_r.edge_pend != 8'h00;
      st_nxt.edge_pend = edges;
    end else begin
      st_nxt.edge_pend = st_r.edge_pend | edges;
    end
    if (REG_REQ.wr && REG_REQ.addr == `REG_MON_SEL) begin
      st_nxt.mon_sel = REG_REQ.wdata;
    end
    if (REG_REQ.wr && REG_REQ.addr == `REG_STREAM_CTRL) begin
      // spare bits are stored as written; the host keeps them zero
      st_nxt.sctl = REG_REQ.wdata[`STREAM_CTRL_BITS-1:0];
    end
    st_nxt.test_out = MONITOR_ENABLE &&
                      TEST_OUTPUT_SELECT == `TEST_SEL_MONITOR &&
                      MONITOR_SERIAL;
    // prescalers are 32 bits wide so the long defaults still fit
    st_nxt.sec_tick = 1'b0;
    if (st_r.sec_pre == 32'(SECOND_CYC - 1)) begin
      st_nxt.sec_pre = 32'h0;
      st_nxt.sec_tick = 1'b1;
    end else begin
      st_nxt.sec_pre = st_r.sec_pre + 32'h1;
    end
    st_nxt.hour_pre = hour_tick ? 32'h0 : st_r.hour_pre + 32'h1;
    if (wr_time || wr_date) begin
      st_nxt.hours = 32'h0;
      st_nxt.hour_pre = 32'h0;
    end else if (hour_tick) begin
      st_nxt.hours = st_r.hours + 32'h1;
    end
    // the period runs only while enabled and restarts on enable
    st_nxt.start = 1'b0;
    if (!st_r.sctl.en) begin
      st_nxt.per_cnt = 32'h0;
    end else if (st_r.per_cnt == 32'(STREAM_PERIOD_CYC - 1)) begin
      st_nxt.per_cnt = 32'h0;
      st_nxt.start = 1'b1;
    end else begin
      st_nxt.per_cnt = st_r.per_cnt + 32'h1;
    end
    st_nxt.rvalid = REG_REQ.rd;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `REG_PIN_CTRL: st_nxt.rdata = {st_r.pin_mask, st_r.pin_dir, 8'h00,
                                       GENERAL_PINS_IN};
        `REG_OP_HOURS: st_nxt.rdata = st_r.hours;
        `REG_TIME_DAY: st_nxt.rdata = time_word;
        `REG_DATE: st_nxt.rdata = date_word;
        `REG_MON_SEL: st_nxt.rdata = st_r.mon_sel;
        `REG_STREAM_CTRL: st_nxt.rdata = {8'h00, st_r.sctl};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  rtc_calendar u_cal (
    .clk(CORE_CLK),
    .nrst(NRST),
    .sec_tick(st_r.sec_tick),
    .load_time(wr_time),
    .load_date(wr_date),
    .wdata(REG_REQ.wdata),
    .time_word(time_word),
    .date_word(date_word)
  );

  stream_serializer u_ser (
    .clk(CORE_CLK),
    .nrst(NRST),
    .start(st_r.start),
    .ctl(st_r.sctl),
    .eng_rd(ENGINE_RD),
    .eng_addr(ENGINE_ADDR),
    .eng_data(ENGINE_DATA),
    .sclk_out(STREAM_CLOCK),
    .sdata_out(STREAM_DATA),
    .frame_out(FRAME_PULSE),
    .busy(ser_busy)
  );

  assign REG_RDATA = st_r.rdata;
  assign REG_RVALID = st_r.rvalid;
  assign GENERAL_PINS_OUT = st_r.pin_out;
  assign GENERAL_PINS_OE = st_r.pin_dir;
  assign PIN_EDGE_FLAG = st_r.edge_flag;
  assign MONITOR_SLOT_ADDR = st_r.mon_sel;
  assign TEST_OUT = st_r.test_out;

  hours_clear_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    wr_time || wr_date |=> st_r.hours == 32'h0)
    else $error("operating hours not cleared");

  hours_step_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    hour_tick && !wr_time && !wr_date
    |=> st_r.hours == $past(st_r.hours) + 32'h1)
    else $error("operating hours not advanced");

  pin_drive_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    wr_pins |=> GENERAL_PINS_OUT ==
      (($past(GENERAL_PINS_OUT) & ~$past(new_dir)) |
       ($past(REG_REQ.wdata[7:0]) & $past(new_dir))))
    else $error("pin output levels wrong");

  pin_dir_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    wr_pins |=> GENERAL_PINS_OE == $past(new_dir))
    else $error("pin direction not taken");

  pin_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    REG_REQ.rd && REG_REQ.addr == `REG_PIN_CTRL
    |=> REG_RVALID && REG_RDATA[7:0] == $past(GENERAL_PINS_IN) &&
        REG_RDATA[15:8] == 8'h00)
    else $error("pin level read wrong");

  edge_report_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    INTERVAL_TICK && st_r.edge_pend != 8'h00 |=> PIN_EDGE_FLAG)
    else $error("pin edge not reported");

  test_gate_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !(MONITOR_ENABLE && TEST_OUTPUT_SELECT == `TEST_SEL_MONITOR)
    |=> !TEST_OUT)
    else $error("monitor leaked to test pin");

  period_start_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_r.start |-> $past(st_r.sctl.en))
    else $error("stream started while disabled");

  stream_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !ser_busy |-> !ENGINE_RD && !STREAM_DATA)
    else $error("stream active while idle");

endmodule : meter_aux_register_bank

// ===== meter_aux_regs.svh
// register offsets, field positions, reset values and timing counts
// of the metering auxiliary register bank; definitions only.
// assumes a 100 MHz core clock and a word-wide register port.
//
// Overview of operation
// - operating-hours register counts elapsed time in hundredths of an hour.
// - any host write to date or time-of-day clears operating hours.
// - date bits 15-8 hold year 0..255, zero meaning year 2000.
// - date bits 23-16 hold month 1..12, bits 31-24 day 1..31.
// - writing the date register loads a new calendar date.
// - time bits 7-0 hold weekday 1..7, one meaning Sunday.
// - time bits 15-8 hold hour 0..23, zero meaning midnight.
// - time bits 23-16 hold minutes, bits 31-24 seconds, each 0..59.
// - writing the time register loads new time and weekday.
// - monitor reaches test pin only when enabled and selector equals 3.
// - monitor selector holds four engine addresses, slot one in top byte.
// - stream enable bit 23 sends the configured block every 397 us.
// - stream bits 7-0 give word count, bits 15-8 start address.
// - stream bit 18 picks frame polarity, zero positive, one negative.
// - bits 20-19 place frame pulses: start, every 8, 16, 32 bits.
// - bit 21 clear runs clock freely; set holds it low when idle.
// - stream bit 22 selects clock rate, zero 5 MHz, one 10 MHz.
// - written pin value drives output pins; input pins ignore it.
// - reading pin value returns the present level of all pins.
// - direction byte bits 23-16 makes pin output when bit is one.
// - masked pin edge sets edge flag in the following interval.
`ifndef METER_AUX_REGS_SVH
`define METER_AUX_REGS_SVH

`define REG_PIN_CTRL 7'h1a
`define REG_OP_HOURS 7'h1e
`define REG_TIME_DAY 7'h1f
`define REG_DATE 7'h20
`define REG_MON_SEL 7'h21
`define REG_STREAM_CTRL 7'h22

`define PIN_VALUE_LSB 0
`define PIN_DIR_LSB 16
`define PIN_MASK_LSB 24
`define STREAM_CTRL_BITS 24

`define TEST_SEL_MONITOR 2'h3

`define RTC_SEC_MAX 8'h3b
`define RTC_MIN_MAX 8'h3b
`define RTC_HOUR_MAX 8'h17
`define RTC_WDAY_MAX 8'h07
`define RTC_MONTH_MAX 8'h0c
`define RTC_FEB 8'h02
`define RTC_CENTURY1 8'h64
`define RTC_CENTURY2 8'hc8

`define RST_YEAR 8'h00
`define RST_MONTH 8'h01
`define RST_DAY 8'h01
`define RST_WDAY 8'h07
`define RST_HOUR 8'h00
`define RST_MIN 8'h00
`define RST_SEC 8'h00

`define CLK_PERIOD_NS 10
`define STREAM_PERIOD_US 397
`define STREAM_PERIOD_CYC (`STREAM_PERIOD_US * 1000 / `CLK_PERIOD_NS)
`define SECOND_S 1
`define SECOND_CYC (`SECOND_S * 1000000000 / `CLK_PERIOD_NS)
`define HOUR_FRACTION_S 36
// 3.6e9 cycles: fits 32 bits only unsigned, so the product is kept unsigned
`define HOUR_FRACTION_CYC (`HOUR_FRACTION_S * 32'h05f5e100 / `CLK_PERIOD_NS * 10)
`define SLOW_CLK_MHZ 5
`define FAST_CLK_MHZ 10
`define SLOW_HALF_CYC (1000 / (`SLOW_CLK_MHZ * 2 * `CLK_PERIOD_NS))
`define FAST_HALF_CYC (1000 / (`FAST_CLK_MHZ * 2 * `CLK_PERIOD_NS))

`endif

// ===== meter_aux_pkg.sv
// types shared by the register bank, the calendar and the stream sender.
// packed layouts follow the register bit positions, msb first.
package meter_aux_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic en;
    logic fast;
    logic gate;
    logic [1:0] fmt;
    logic pol;
    logic [1:0] spare;
    logic [7:0] start;
    logic [7:0] count;
  } stream_ctrl_t;

  typedef struct packed {
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] unused;
  } date_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
  } tod_t;

  typedef struct packed {
    date_t date;
    tod_t tod;
  } cal_state_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LOAD = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    ser_state_t state;
    logic sclk;
    logic [3:0] div;
    logic [4:0] bitn;
    logic [7:0] left;
    logic [7:0] addr;
    logic [31:0] shreg;
    logic [31:0] nxt;
    logic nxt_valid;
    logic rd;
    logic rd_pend;
    logic first;
    logic sdata;
    logic fr_act;
    logic fr;
  } ser_t;

  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_dir;
    logic [7:0] pin_mask;
    logic [7:0] pin_prev;
    logic [7:0] edge_pend;
    logic edge_flag;
    logic [31:0] mon_sel;
    stream_ctrl_t sctl;
    logic [31:0] hours;
    logic [31:0] hour_pre;
    logic [31:0] sec_pre;
    logic [31:0] per_cnt;
    logic start;
    logic sec_tick;
    logic test_out;
    logic [31:0] rdata;
    logic rvalid;
  } top_t;

endpackage : meter_aux_pkg

// ===== rtc_calendar.sv
// calendar and time-of-day keeper, advanced by a one-second tick.
// assumes load strobes are single-cycle and data is binary coded.
`timescale 1ns/1ns
`include "meter_aux_regs.svh"
module rtc_calendar (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sec_tick,
  input wire logic load_time,
  input wire logic load_date,
  input wire logic [31:0] wdata,
  output logic [31:0] time_word,
  output logic [31:0] date_word
);
  localparam meter_aux_pkg::cal_state_t CAL_RST = '{
    date: '{day: `RST_DAY, month: `RST_MONTH, year: `RST_YEAR,
            unused: 8'h00},
    tod: '{sec: `RST_SEC, min: `RST_MIN, hour: `RST_HOUR,
           wday: `RST_WDAY}};

  meter_aux_pkg::cal_state_t st_r;
  meter_aux_pkg::cal_state_t st_nxt;

  // century years 2100 and 2200 are not leap years
  function automatic logic [7:0] month_days(input logic [7:0] month,
                                            input logic [7:0] year);
    logic leap;
    leap = (year[1:0] == 2'h0) && (year != `RTC_CENTURY1) &&
           (year != `RTC_CENTURY2);
    case (month)
      `RTC_FEB: month_days = leap ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
      default: month_days = 8'h1f;
    endcase
  endfunction : month_days

  always_comb begin
    st_nxt = st_r;
    if (sec_tick) begin
      if (st_r.tod.sec != `RTC_SEC_MAX) begin
        st_nxt.tod.sec = st_r.tod.sec + 8'h01;
      end else begin
        st_nxt.tod.sec = 8'h00;
        if (st_r.tod.min != `RTC_MIN_MAX) begin
          st_nxt.tod.min = st_r.tod.min + 8'h01;
        end else begin
          st_nxt.tod.min = 8'h00;
          if (st_r.tod.hour != `RTC_HOUR_MAX) begin
            st_nxt.tod.hour = st_r.tod.hour + 8'h01;
          end else begin
            st_nxt.tod.hour = 8'h00;
            st_nxt.tod.wday = (st_r.tod.wday >= `RTC_WDAY_MAX) ? 8'h01 :
                              st_r.tod.wday + 8'h01;
            if (st_r.date.day <
                month_days(st_r.date.month, st_r.date.year)) begin
              st_nxt.date.day = st_r.date.day + 8'h01;
            end else begin
              st_nxt.date.day = 8'h01;
              if (st_r.date.month < `RTC_MONTH_MAX) begin
                st_nxt.date.month = st_r.date.month + 8'h01;
              end else begin
                st_nxt.date.month = 8'h01;
                // year 255 wraps to 0, the register has no wider range
                st_nxt.date.year = st_r.date.year + 8'h01;
              end
            end
          end
        end
      end
    end
    // a host load overrides the tick that lands in the same cycle
    if (load_time) begin
      st_nxt.tod = wdata;
    end
    if (load_date) begin
      st_nxt.date = {wdata[31:8], 8'h00};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= CAL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign time_word = st_r.tod;
  assign date_word = st_r.date;

  time_load_a: assert property (@(posedge clk) disable iff (!nrst)
    load_time |=> time_word == $past(wdata))
    else $error("time load not taken");

  date_load_a: assert property (@(posedge clk) disable iff (!nrst)
    load_date |=> date_word[31:8] == $past(wdata[31:8]))
    else $error("date load not taken");

  sec_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    sec_tick && !load_time && time_word[31:24] == `RTC_SEC_MAX
    |=> time_word[31:24] == 8'h00 &&
        time_word[23:16] != $past(time_word[23:16]))
    else $error("seconds rollover wrong");

endmodule : rtc_calendar

// ===== stream_serializer.sv
// synchronous serial sender: reads a block of engine words and shifts
// them out msb first with clock and frame pulse.
// assumes engine read data is valid one cycle after the read strobe.
`timescale 1ns/1ns
`include "meter_aux_regs.svh"
module stream_serializer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input meter_aux_pkg::stream_ctrl_t ctl,
  output logic eng_rd,
  output logic [7:0] eng_addr,
  input wire logic [31:0] eng_data,
  output logic sclk_out,
  output logic sdata_out,
  output logic frame_out,
  output logic busy
);
  meter_aux_pkg::ser_t s_r;
  meter_aux_pkg::ser_t s_nxt;
  logic fall;
  logic [3:0] half;

  function automatic logic frame_mark(input logic [1:0] fmt,
                                      input logic [4:0] bitn,
                                      input logic first);
    case (fmt)
      2'h0: frame_mark = first && (bitn == 5'h1f);
      2'h1: frame_mark = bitn[2:0] == 3'h7;
      2'h2: frame_mark = bitn[3:0] == 4'hf;
      2'h3: frame_mark = bitn == 5'h1f;
      default: frame_mark = 1'b0;
    endcase
  endfunction : frame_mark

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = 1'b0;
    fall = 1'b0;
    half = ctl.fast ? 4'(`FAST_HALF_CYC) : 4'(`SLOW_HALF_CYC);
    // the divider runs free so an ungated clock keeps toggling
    if (s_r.div == 4'h0) begin
      s_nxt.div = half - 4'h1;
      s_nxt.sclk = ~s_r.sclk;
      fall = s_r.sclk;
    end else begin
      s_nxt.div = s_r.div - 4'h1;
    end
    if (s_r.rd_pend) begin
      s_nxt.nxt = eng_data;
      s_nxt.nxt_valid = 1'b1;
    end
    s_nxt.rd_pend = s_r.rd;
    case (s_r.state)
      meter_aux_pkg::SER_IDLE: begin
        s_nxt.sdata = 1'b0;
        s_nxt.fr_act = 1'b0;
        s_nxt.nxt_valid = 1'b0;
        // a zero count sends nothing for that period
        if (start && ctl.count != 8'h00) begin
          s_nxt.rd = 1'b1;
          s_nxt.addr = ctl.start;
          s_nxt.left = ctl.count - 8'h01;
          s_nxt.first = 1'b1;
          s_nxt.state = meter_aux_pkg::SER_LOAD;
        end
      end
      meter_aux_pkg::SER_LOAD, meter_aux_pkg::SER_SHIFT: begin
        if (fall) begin
          if (s_r.state == meter_aux_pkg::SER_SHIFT && s_r.bitn != 5'h0)
          begin
            s_nxt.bitn = s_r.bitn - 5'h1;
            s_nxt.shreg = {s_r.shreg[30:0], 1'b0};
            s_nxt.sdata = s_r.shreg[30];
            s_nxt.fr_act = frame_mark(ctl.fmt, s_r.bitn - 5'h1,
                                      1'b0);
          end else if (s_r.nxt_valid) begin
            // next word is prefetched while the current one shifts
            s_nxt.shreg = s_r.nxt;
            s_nxt.sdata = s_r.nxt[31];
            s_nxt.bitn = 5'h1f;
            s_nxt.nxt_valid = 1'b0;
            s_nxt.first = 1'b0;
            s_nxt.fr_act = frame_mark(ctl.fmt, 5'h1f, s_r.first);
            s_nxt.state = meter_aux_pkg::SER_SHIFT;
            if (s_r.left != 8'h00) begin
              s_nxt.rd = 1'b1;
              s_nxt.addr = s_r.addr + 8'h01;
              s_nxt.left = s_r.left - 8'h01;
            end
          end else if (s_r.state == meter_aux_pkg::SER_SHIFT) begin
            s_nxt.sdata = 1'b0;
            s_nxt.fr_act = 1'b0;
            s_nxt.state = meter_aux_pkg::SER_IDLE;
          end
        end
      end
      default: begin
        s_nxt.state = meter_aux_pkg::SER_IDLE;
      end
    endcase
    s_nxt.fr = s_nxt.fr_act ^ ctl.pol;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign eng_rd = s_r.rd;
  assign eng_addr = s_r.addr;
  assign sdata_out = s_r.sdata;
  assign frame_out = s_r.fr;
  assign busy = s_r.state != meter_aux_pkg::SER_IDLE;
  assign sclk_out = ctl.gate ?
                    (s_r.sclk && s_r.state == meter_aux_pkg::SER_SHIFT) :
                    s_r.sclk;

  sequence block_begin_s;
    start && s_r.state == meter_aux_pkg::SER_IDLE && ctl.count != 8'h00;
  endsequence
  sequence first_fetch_s;
    eng_rd && eng_addr == $past(ctl.start);
  endsequence

  block_fetch_a: assert property (@(posedge clk) disable iff (!nrst)
    block_begin_s |=> first_fetch_s)
    else $error("block fetch not at start address");

  gate_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    ctl.gate && s_r.state != meter_aux_pkg::SER_SHIFT |-> !sclk_out)
    else $error("gated clock active while idle");

  frame_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    s_r.state == meter_aux_pkg::SER_IDLE && $stable(ctl.pol) &&
    $past(s_r.state) == meter_aux_pkg::SER_IDLE |-> frame_out == ctl.pol)
    else $error("frame idle level wrong");

  fast_half_a: assert property (@(posedge clk) disable iff (!nrst)
    ctl.fast && $stable(ctl.fast) && $rose(s_r.sclk)
    |-> s_r.sclk [*5] ##1 !s_r.sclk)
    else $error("fast clock half period wrong");

endmodule : stream_serializer

// ===== engine_ram_model.sv
// engine data memory seen by the stream sender.
// assumes reads are single-cycle pulses answered on the next cycle.
`timescale 1ns/1ns
module engine_ram_model (
  input wire logic clk,
  input wire logic rd,
  input wire logic [7:0] addr,
  output logic [31:0] data
);
  // between answers the bus toggles, so a stale word is never re-used
  always_ff @(posedge clk) begin
    if (rd) begin
      data <= {addr, ~addr, 8'h5a, addr};
    end else begin
      data <= ~data;
    end
  end
endmodule : engine_ram_model

// ===== tb_top.sv
// register-port tests of the auxiliary bank: calendar, hours, pins,
// edge flag, monitor path and four stream blocks. uses shortened counts.
`timescale 1ns/1ns
`include "meter_aux_regs.svh"
`define CHK(g,e) begin total_checks++; if ((g)!==(e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 0;
  logic nrst = 0;
  logic tick = 0;
  logic mon_en = 0;
  logic mon_ser = 0;
  logic [1:0] tsel = 2'h0;
  logic [7:0] ext = 8'h70;
  logic [7:0] pout, poe, pad, eng_addr;
  logic [31:0] rdata, slot, eng_data, d, bits;
  logic rvalid, flag, tout, eng_rd, sclk, sdata, frame, prev;
  meter_aux_pkg::reg_req_t req = '0;
  int num_errors = 0;
  int total_checks = 0;
  int n, t0;
  // pads resolve to the bank where it drives, otherwise the board level
  assign pad = (pout & poe) | (ext & ~poe);
  meter_aux_register_bank #(.STREAM_PERIOD_CYC(200), .SECOND_CYC(20),
    .HOUR_FRACTION_CYC(30)) dut (.CORE_CLK(clk), .NRST(nrst),
    .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .GENERAL_PINS_IN(pad), .GENERAL_PINS_OUT(pout), .GENERAL_PINS_OE(poe),
    .INTERVAL_TICK(tick), .PIN_EDGE_FLAG(flag), .MONITOR_ENABLE(mon_en),
    .TEST_OUTPUT_SELECT(tsel), .MONITOR_SERIAL(mon_ser),
    .MONITOR_SLOT_ADDR(slot), .TEST_OUT(tout), .ENGINE_RD(eng_rd),
    .ENGINE_ADDR(eng_addr), .ENGINE_DATA(eng_data), .STREAM_CLOCK(sclk),
    .STREAM_DATA(sdata), .FRAME_PULSE(frame));
  engine_ram_model ram (.clk(clk), .rd(eng_rd), .addr(eng_addr),
    .data(eng_data));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge clk);
    req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    v = rdata;
  endtask : rd
  task automatic pulse_tick(input logic e);
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    @(negedge clk);
    `CHK(flag, e)
  endtask : pulse_tick
  // ungated slow block; its first bit is the first rise at which the frame
  // level leaves the idle polarity, earlier rises are idle clocking
  task automatic stream_run(input logic [31:0] c, input logic [63:0] ed,
                            input logic [63:0] ef);
    logic [63:0] gd, gf;
    int k, m, t1, idle;
    gd = '0;
    gf = '0;
    m = 0;
    t1 = 0;
    idle = 0;
    prev = 1'b0;
    wr(`REG_STREAM_CTRL, c);
    @(negedge clk);
    `CHK(frame, c[18])
    for (k = 0; k < 2000 && m < 32 * int'(c[7:0]); k++) begin
      @(negedge clk);
      if (sclk && !prev && m == 0 && frame === c[18]) begin
        idle++;
      end else if (sclk && !prev) begin
        if (m == 1) `CHK(k - t1, 20)
        t1 = k;
        gd = {gd[62:0], sdata};
        gf = {gf[62:0], frame};
        m++;
      end
      prev = sclk;
    end
    `CHK(idle > 0, 1'b1)
    `CHK(gd, ed)
    `CHK(gf, ef)
    wr(`REG_STREAM_CTRL, 32'h0);
  endtask : stream_run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    #900000;
    num_errors++;
    $display("MISMATCH t=%0t run limit reached", $time);
    summarize();
  end
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rd(`REG_DATE, d);
    `CHK(d, 32'h01010000)
    wr(`REG_DATE, 32'h1f0c6300);
    wr(`REG_TIME_DAY, 32'h3b3b1707);
    rd(`REG_OP_HOURS, d);
    `CHK(d, 32'h0)
    // poll until the next second lands; it rolls every field over
    for (n = 0; n < 30 && d !== 32'h00000001; n++) rd(`REG_TIME_DAY, d);
    `CHK(d, 32'h00000001)
    rd(`REG_DATE, d);
    `CHK(d, 32'h01016400)
    $display("calendar test done");
    wr(`REG_TIME_DAY, 32'h0a0b0c02);
    repeat (95) @(negedge clk);
    rd(`REG_OP_HOURS, d);
    `CHK(d, 32'h3)
    $display("hours test done");
    wr(`REG_PIN_CTRL, 32'h800fff05);
    rd(`REG_PIN_CTRL, d);
    `CHK(d, 32'h800f0075)
    `CHK({poe, pout & poe}, 16'h0f05)
    pulse_tick(1'b0);
    ext = 8'h60;
    pulse_tick(1'b0);
    ext = 8'he0;
    pulse_tick(1'b1);
    pulse_tick(1'b0);
    $display("pin test done");
    wr(`REG_MON_SEL, 32'h11223344);
    `CHK(slot, 32'h11223344)
    mon_en = 1'b1;
    tsel = 2'h3;
    mon_ser = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(tout, 1'b1)
    tsel = 2'h2;
    repeat (2) @(negedge clk);
    `CHK(tout, 1'b0)
    tsel = 2'h3;
    mon_en = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(tout, 1'b0)
    $display("monitor test done");
    wr(`REG_STREAM_CTRL, 32'h00f84001);
    rd(`REG_STREAM_CTRL, d);
    `CHK(d, 32'h00f84001)
    `CHK(sclk, 1'b0)
    n = 0;
    prev = 1'b0;
    for (int i = 0; i < 1000 && n < 32; i++) begin
      @(negedge clk);
      if (eng_rd) `CHK(eng_addr, 8'h40)
      if (sclk && !prev) begin
        if (n == 0) `CHK(frame, 1'b1)
        if (n == 0) t0 = i;
        if (n == 1) `CHK(i - t0, 10)
        bits = {bits[30:0], sdata};
        n++;
      end
      prev = sclk;
    end
    `CHK(bits, 32'h40bf5a40)
    wr(`REG_STREAM_CTRL, 32'h0);
    // once-per-block frame across two words, negative polarity
    stream_run(32'h00844102, 64'h41be5a4142bd5a42,
               64'h7fffffffffffffff);
    stream_run(32'h008c4301, 64'h43bc5a43, 64'h7f7f7f7f);
    stream_run(32'h00904401, 64'h44bb5a44, 64'h80008000);
    $display("stream test done");
    summarize();
  end
endmodule : tb_top
